/* rtl/cod_ctrl.sv */
// What this block does
// [R1] Divide clock by 14-bit ratio, minimum ten
// [R2] Regulator enable bit powers divider supply
// [R3] Disabled-state field sets idle pair level
// [R4] Force-disable bit disables the driver
// [R5] Power-down tri-states outputs, overrides enables
// [R6] CMOS field selects output phase pattern
// [R7] LVDS common-mode code selects level
// [R8] HCSL termination bit connects internal resistor
// [R9] Bias enable bit powers driver bias
// [R10] Type field selects HCSL, LVDS, CMOS
// [R11] Swing code sets differential amplitude
// [R12] LVDS amplitude bit selects 350/400 mV
// [R13] Software avoids reserved codes and fields
`include "cod_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module cod_ctrl #(
    parameter int RATIO_W = `COD_RATIO_W
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic reset, // Synchronous, active high
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Low when answered
    output logic [1:0] avs_response, // 00 okay, 10 slave error
    output logic clock_out_true, // True output level
    output logic clock_out_true_oe, // True output driven
    output logic clock_out_complement, // Complement output level
    output logic clock_out_complement_oe, // Complement output driven
    output logic divider_regulator_on, // Divider supply regulator
    output logic driver_bias_on, // Driver bias circuit
    output logic hcsl_term_on, // Internal termination
    output logic [1:0] driver_type, // Active driver type
    output logic [1:0] common_mode_level, // LVDS common-mode code
    output logic [3:0] swing_code, // Amplitude code
    output logic lvds_amp_high, // LVDS 400 mV select
    output logic driver_power_down // Driver powered off
);

    logic [15:0] div_cfg_q;
    logic [7:0] en_cfg_q;
    logic [7:0] type_cfg_q;
    logic [7:0] swing_cfg_q;
    logic ack_q;
    logic [RATIO_W-1:0] cnt_q;
    logic div_clk_q;
    logic [RATIO_W-1:0] ratio;
    logic div_run;
    logic enabled;
    logic true_d;
    logic comp_d;
    logic true_oe_d;
    logic comp_oe_d;
    logic [31:0] rd_d;
    logic bad_addr;

    // Merge byte lanes into the old value under a writable mask
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
            input logic [3:0] be, input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
        merge16 = (old & ~lanes) | (wd[15:0] & lanes);
    endfunction

    assign ratio = div_cfg_q[RATIO_W-1:0];
    // Ratios under ten are invalid; the divider is held rather than run out of spec
    assign div_run = div_cfg_q[`COD_DIV_REG_BIT] && (ratio >= `COD_RATIO_MIN); // [R1] [R2]
    assign enabled = !en_cfg_q[`COD_DIS_BIT]; // [R4]
    assign bad_addr = !(avs_address == `COD_ADDR_DIV || avs_address == `COD_ADDR_EN
        || avs_address == `COD_ADDR_TYPE || avs_address == `COD_ADDR_SWING
        || avs_address == `COD_ADDR_STATUS);

    // One wait cycle on every access keeps read data registered
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // Configuration registers, written at the acknowledging edge
    // Reserved bits of the divider and enable words are masked so they keep reading their reset value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_cfg_q <= `COD_DIV_RST; // [R1] [R2]
            en_cfg_q <= `COD_EN_RST;
            type_cfg_q <= `COD_TYPE_RST;
            swing_cfg_q <= `COD_SWING_RST;
        end else if (avs_write && ack_q) begin
            unique case (avs_address)
                `COD_ADDR_DIV: div_cfg_q <= merge16(div_cfg_q, avs_writedata,
                    avs_byteenable, `COD_DIV_WMASK);
                `COD_ADDR_EN: en_cfg_q <= 8'(merge16({8'h00, en_cfg_q}, avs_writedata,
                    avs_byteenable, {8'h00, `COD_EN_WMASK}));
                `COD_ADDR_TYPE: type_cfg_q <= 8'(merge16({8'h00, type_cfg_q}, avs_writedata,
                    avs_byteenable, 16'h00ff)); // [R6] [R7] [R8] [R9] [R10]
                `COD_ADDR_SWING: swing_cfg_q <= 8'(merge16({8'h00, swing_cfg_q}, avs_writedata,
                    avs_byteenable, 16'h00ff)); // [R11] [R12]
                default: ;
            endcase
        end
    end

    // Read mux; status word shows divider and output state
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address)
            `COD_ADDR_DIV: rd_d = {16'h0000, div_cfg_q};
            `COD_ADDR_EN: rd_d = {24'h000000, en_cfg_q};
            `COD_ADDR_TYPE: rd_d = {24'h000000, type_cfg_q};
            `COD_ADDR_SWING: rd_d = {24'h000000, swing_cfg_q};
            `COD_ADDR_STATUS: rd_d = {28'h0000000, enabled, div_run, div_clk_q,
                en_cfg_q[`COD_PD_BIT]};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Bus answer registers
    // Waitrequest idles high and drops for the one cycle that answers a request
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
            avs_waitrequest <= 1'b1;
        end else begin
            avs_readdata <= rd_d;
            avs_response <= bad_addr ? 2'h2 : 2'h0;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        end
    end

    // Divider: half period low, rest high; a ratio change takes effect at once, even mid-period
    always_ff @(posedge sys_clk) begin
        if (reset || !div_run) begin
            cnt_q <= '0;
            div_clk_q <= 1'b0;
        end else if (cnt_q >= ratio - RATIO_W'(1)) begin
            cnt_q <= '0;
            div_clk_q <= 1'b0; // [R1]
        end else begin
            cnt_q <= cnt_q + RATIO_W'(1);
            if (cnt_q == (ratio >> 1) - RATIO_W'(1)) begin
                div_clk_q <= 1'b1;
            end
        end
    end

    // Output pattern from type, enable, disabled state and power-down
    always_comb begin
        true_d = div_clk_q;
        comp_d = !div_clk_q;
        true_oe_d = 1'b1;
        comp_oe_d = 1'b1;
        if (type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_CMOS) begin
            unique case (type_cfg_q[`COD_CMOS_LSB +: 2]) // [R6]
                cod_pkg::COD_CM_SAME: comp_d = div_clk_q;
                cod_pkg::COD_CM_OPP: comp_d = !div_clk_q;
                cod_pkg::COD_CM_TRUE: comp_d = 1'b0;
                cod_pkg::COD_CM_COMP: true_d = 1'b0;
            endcase
        end
        if (!enabled) begin
            unique case (en_cfg_q[`COD_DSTATE_LSB +: 2]) // [R3]
                cod_pkg::COD_DIS_LOW: begin
                    true_d = 1'b0;
                    comp_d = (type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_LVDS);
                end
                cod_pkg::COD_DIS_LOHI: begin
                    true_d = 1'b0;
                    comp_d = 1'b1;
                end
                cod_pkg::COD_DIS_HIZ: begin
                    true_d = 1'b0;
                    comp_d = 1'b0;
                    true_oe_d = 1'b0;
                    comp_oe_d = 1'b0;
                end
                cod_pkg::COD_DIS_RUN: ;
            endcase
        end
        // Power-down wins over every enable source
        if (en_cfg_q[`COD_PD_BIT]) begin
            true_d = 1'b0;
            comp_d = 1'b0;
            true_oe_d = 1'b0; // [R5]
            comp_oe_d = 1'b0; // [R5]
        end
    end

    // Registered pins and analog controls
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clock_out_true <= 1'b0;
            clock_out_complement <= 1'b0;
            clock_out_true_oe <= 1'b0;
            clock_out_complement_oe <= 1'b0;
            divider_regulator_on <= 1'b1;
            driver_bias_on <= 1'b1;
            hcsl_term_on <= 1'b1;
            driver_type <= 2'h0;
            common_mode_level <= 2'h2;
            swing_code <= 4'hb;
            lvds_amp_high <= 1'b0;
            driver_power_down <= 1'b0;
        end else begin
            clock_out_true <= true_d;
            clock_out_complement <= comp_d;
            clock_out_true_oe <= true_oe_d;
            clock_out_complement_oe <= comp_oe_d;
            divider_regulator_on <= div_cfg_q[`COD_DIV_REG_BIT]; // [R2]
            driver_bias_on <= type_cfg_q[`COD_BIAS_BIT]; // [R9]
            hcsl_term_on <= type_cfg_q[`COD_TERM_BIT]; // [R8]
            driver_type <= type_cfg_q[`COD_TYPE_LSB +: 2]; // [R10]
            common_mode_level <= type_cfg_q[`COD_CM_LSB +: 2]; // [R7]
            swing_code <= swing_cfg_q[`COD_SWING_LSB +: 4]; // [R11]
            lvds_amp_high <= swing_cfg_q[`COD_LVDS_AMP_BIT]; // [R12]
            driver_power_down <= en_cfg_q[`COD_PD_BIT]; // [R5]
        end
    end

    // Assertions; every pin is registered, so each check looks one cycle after
    // the configuration that should drive it
    // Power-down must override every enable source and disabled state
    a_pd_tristate: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
        en_cfg_q[`COD_PD_BIT] |=> !clock_out_true_oe && !clock_out_complement_oe)
        else $error("power-down did not tri-state outputs");
    // Low/high hold is the same for every driver type
    a_dis_lohi: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
        (!enabled && !en_cfg_q[`COD_PD_BIT]
        && en_cfg_q[`COD_DSTATE_LSB +: 2] == cod_pkg::COD_DIS_LOHI)
        |=> !clock_out_true && clock_out_complement)
        else $error("disabled level wrong");
    // Hi-Z hold releases both pins while the driver stays powered
    a_dis_hiz: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
        (!enabled && !en_cfg_q[`COD_PD_BIT]
        && en_cfg_q[`COD_DSTATE_LSB +: 2] == cod_pkg::COD_DIS_HIZ)
        |=> !clock_out_true_oe && !clock_out_complement_oe)
        else $error("hi-z hold still driving");
    // LVDS cannot rest with both legs low, so its low hold is low/high
    a_lvds_low: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
        (!enabled && !en_cfg_q[`COD_PD_BIT]
        && en_cfg_q[`COD_DSTATE_LSB +: 2] == cod_pkg::COD_DIS_LOW
        && type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_LVDS)
        |=> !clock_out_true && clock_out_complement)
        else $error("lvds low hold wrong");
    // Force-disable with the low hold pulls an HCSL pair to low/low
    a_force_dis: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
        (en_cfg_q[`COD_DIS_BIT] && en_cfg_q[`COD_DSTATE_LSB +: 2] == cod_pkg::COD_DIS_LOW
        && type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_HCSL)
        |=> !clock_out_true && !clock_out_complement)
        else $error("force-disable ignored");
    // With no disable source the pair is driven
    a_enable_drive: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
        (!en_cfg_q[`COD_DIS_BIT] && !en_cfg_q[`COD_PD_BIT])
        |=> clock_out_true_oe && clock_out_complement_oe)
        else $error("enabled driver not driving");
    // True-only CMOS: complement parked low, true follows the divider
    a_cmos_true: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
        (enabled && !en_cfg_q[`COD_PD_BIT]
        && type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_CMOS
        && type_cfg_q[`COD_CMOS_LSB +: 2] == cod_pkg::COD_CM_TRUE)
        |=> !clock_out_complement && clock_out_true == $past(div_clk_q))
        else $error("cmos pattern wrong");
    // An out-of-range ratio must never toggle the divider
    a_div_low: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
        (ratio < `COD_RATIO_MIN) |=> !div_clk_q)
        else $error("divider ran below minimum ratio");
    // Analog controls are plain registered copies of their fields
    a_reg_follow: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
        1'b1 |=> divider_regulator_on == $past(div_cfg_q[`COD_DIV_REG_BIT]))
        else $error("regulator output stale");
    a_cm_follow: assert property (@(posedge sys_clk) disable iff (reset) // [R7] [R8] [R9] [R10]
        1'b1 |=> (common_mode_level == $past(type_cfg_q[`COD_CM_LSB +: 2])
        && hcsl_term_on == $past(type_cfg_q[`COD_TERM_BIT])
        && driver_bias_on == $past(type_cfg_q[`COD_BIAS_BIT])
        && driver_type == $past(type_cfg_q[`COD_TYPE_LSB +: 2])))
        else $error("type controls stale");
    a_swing_follow: assert property (@(posedge sys_clk) disable iff (reset) // [R11] [R12]
        1'b1 |=> (swing_code == $past(swing_cfg_q[`COD_SWING_LSB +: 4])
        && lvds_amp_high == $past(swing_cfg_q[`COD_LVDS_AMP_BIT])))
        else $error("swing controls stale");
    // Main scenarios to reach: divider running, power-down, hi-z hold,
    // a disabled LVDS pair and a rejected short ratio
    c_div_edge: cover property (@(posedge sys_clk) disable iff (reset) $rose(div_clk_q));
    c_pd: cover property (@(posedge sys_clk) disable iff (reset) $rose(driver_power_down));
    c_hiz: cover property (@(posedge sys_clk) disable iff (reset)
        !enabled && en_cfg_q[`COD_DSTATE_LSB +: 2] == cod_pkg::COD_DIS_HIZ);
    c_lvds_hold: cover property (@(posedge sys_clk) disable iff (reset)
        !enabled && type_cfg_q[`COD_TYPE_LSB +: 2] == cod_pkg::COD_LVDS);
    c_short_ratio: cover property (@(posedge sys_clk) disable iff (reset)
        div_cfg_q[`COD_DIV_REG_BIT] && ratio < `COD_RATIO_MIN);

endmodule // cod_ctrl

`default_nettype wire

/* rtl/cod_defines.svh */
`ifndef COD_DEFINES_SVH
`define COD_DEFINES_SVH

// Register word byte addresses
`define COD_ADDR_DIV     5'h00
`define COD_ADDR_EN      5'h04
`define COD_ADDR_TYPE    5'h08
`define COD_ADDR_SWING   5'h0c
`define COD_ADDR_STATUS  5'h10

// Divider config fields
`define COD_RATIO_W       14
`define COD_RATIO_RST     14'h0069
`define COD_RATIO_MIN     14'h000a
`define COD_DIV_REG_BIT   15
`define COD_DIV_WMASK     16'hbfff
`define COD_DIV_RST       16'h8069

// Driver enable fields
`define COD_PD_BIT        0
`define COD_DIS_BIT       1
`define COD_DSTATE_LSB    2
`define COD_EN_WMASK      8'h0f
`define COD_EN_RST        8'h00

// Driver type fields
`define COD_TYPE_LSB      0
`define COD_BIAS_BIT      2
`define COD_TERM_BIT      3
`define COD_CM_LSB        4
`define COD_CMOS_LSB      6
`define COD_TYPE_RST      8'h6c

// Swing fields
`define COD_LVDS_AMP_BIT  3
`define COD_SWING_LSB     4
`define COD_SWING_RST     8'hb4

`endif

/* rtl/cod_pkg.sv */
package cod_pkg;

    // Driver type codes
    typedef enum logic [1:0] {
        COD_HCSL = 2'h0,
        COD_RSVD = 2'h1,
        COD_LVDS = 2'h2,
        COD_CMOS = 2'h3
    } cod_type_t;

    // Disabled pair level codes
    typedef enum logic [1:0] {
        COD_DIS_LOW = 2'h0,
        COD_DIS_LOHI = 2'h1,
        COD_DIS_HIZ = 2'h2,
        COD_DIS_RUN = 2'h3
    } cod_dstate_t;

    // CMOS drive pattern codes
    typedef enum logic [1:0] {
        COD_CM_SAME = 2'h0,
        COD_CM_OPP = 2'h1,
        COD_CM_TRUE = 2'h2,
        COD_CM_COMP = 2'h3
    } cod_cmos_t;

endpackage

/* testbench/cod_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module cod_ctrl_tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic t_o, t_oe, c_o, c_oe, reg_on, bias_on, term_on, amp_hi, pd;
    logic [1:0] dtype, cm;
    logic [3:0] swing;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] q;

    cod_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .clock_out_true(t_o), .clock_out_true_oe(t_oe), .clock_out_complement(c_o),
        .clock_out_complement_oe(c_oe), .divider_regulator_on(reg_on),
        .driver_bias_on(bias_on), .hcsl_term_on(term_on), .driver_type(dtype),
        .common_mode_level(cm), .swing_code(swing), .lvds_amp_high(amp_hi),
        .driver_power_down(pd));

    // Free-running 200 MHz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon cycle; the request stands until the rising edge at which waitrequest
    // is sampled low, the answer is taken at that edge, and only then released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic [1:0] rr);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rq = avs_readdata;
        rr = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic [1:0] rr;
        bus(1'b1, a, d, rq, rr);
        chk({30'h0, rr}, 32'h0);
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] rq);
        logic [1:0] rr;
        bus(1'b0, a, 32'h0, rq, rr);
    endtask

    // Watch the pins for 40 cycles: rising edges and high counts
    task automatic watch(output int nt, output int t1, output int c1, output int eq);
        logic p;
        nt = 0; t1 = 0; c1 = 0; eq = 0;
        p = t_o;
        repeat (40) begin
            @(negedge sys_clk);
            if (t_o === 1'b1 && p === 1'b0) nt++;
            if (t_o === 1'b1) t1++;
            if (c_o === 1'b1) c1++;
            if (c_o === t_o) eq++;
            p = t_o;
        end
    endtask

    task automatic t_reset;
        rd(5'h00, q); chk(q, 32'h8069);
        rd(5'h04, q); chk(q, 32'h00);
        rd(5'h08, q); chk(q, 32'h6c);
        rd(5'h0c, q); chk(q, 32'hb4);
        chk({reg_on, bias_on, term_on, dtype, cm, swing, amp_hi, pd}, 13'h1cac);
        $display("test reset done");
    endtask

    task automatic t_fields;
        logic [1:0] rr;
        logic [7:0] v;
        bus(1'b0, 5'h14, 32'h0, q, rr);
        chk({rr, q}, {2'h2, 32'h0});
        wr(5'h00, 32'hffff); rd(5'h00, q); chk(q, 32'hbfff);
        wr(5'h04, 32'hff); rd(5'h04, q); chk(q, 32'h0f);
        for (int i = 0; i < 4; i++) begin
            if (i == 1) continue;
            v = {2'(i), 2'(i), i[0], ~i[0], 2'(i)};
            wr(5'h08, {24'h0, v}); rd(5'h08, q); chk(q, {24'h0, v});
            chk({dtype, cm, term_on, bias_on}, {2'(i), 2'(i), i[0], ~i[0]});
        end
        for (int s = 0; s < 16; s++) begin
            wr(5'h0c, {24'h0, 4'(s), s[0], 3'h4});
            chk({swing, amp_hi}, {4'(s), s[0]});
        end
        $display("test fields done");
    endtask

    task automatic t_divider;
        int nt, t1, c1, eq;
        wr(5'h04, 32'h00);
        wr(5'h00, 32'h800a);
        for (int m = 0; m < 4; m++) begin
            wr(5'h08, {24'h0, 2'(m), 6'h2f});
            watch(nt, t1, c1, eq);
            chk(nt, (m == 3) ? 0 : 4);
            chk(t1, (m == 3) ? 0 : 20);
            chk(c1, (m == 2) ? 0 : 20);
            chk(eq, (m == 0) ? 40 : (m == 1) ? 0 : 20);
        end
        wr(5'h08, 32'hbf);
        wr(5'h00, 32'h8009); watch(nt, t1, c1, eq); chk(t1, 0);
        wr(5'h00, 32'h000a); watch(nt, t1, c1, eq); chk({reg_on, 6'(t1)}, 7'h00);
        wr(5'h00, 32'h800a); watch(nt, t1, c1, eq); chk({reg_on, 6'(t1)}, 7'h54);
        $display("test divider done");
    endtask

    task automatic t_enable;
        int nt, t1, c1, eq;
        wr(5'h08, 32'h6c);
        wr(5'h04, 32'h02); chk({t_o, c_o, t_oe, c_oe}, 4'h3);
        wr(5'h04, 32'h06); chk({t_o, c_o, t_oe, c_oe}, 4'h7);
        wr(5'h04, 32'h0a); chk({t_oe, c_oe}, 2'h0);
        wr(5'h04, 32'h0e); watch(nt, t1, c1, eq); chk({t_oe, c_oe, 4'(nt)}, 6'h34);
        wr(5'h08, 32'h6e);
        wr(5'h04, 32'h02); chk({t_o, c_o, t_oe, c_oe}, 4'h7);
        wr(5'h04, 32'h00); watch(nt, t1, c1, eq); chk({t_oe, c_oe, 4'(nt)}, 6'h34);
        wr(5'h04, 32'h01); chk({pd, t_oe, c_oe}, 3'h4);
        rd(5'h10, q); chk(q & 32'h0000_000d, 32'h0000_000d);
        wr(5'h04, 32'h0f); chk({pd, t_oe, c_oe}, 3'h4);
        wr(5'h04, 32'h0d); chk({pd, t_oe, c_oe}, 3'h4);
        wr(5'h04, 32'h00); chk({pd, t_oe, c_oe}, 3'h3);
        $display("test enable done");
    endtask

    task automatic results;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cycle ceiling well above the several hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_fields();
        t_divider();
        t_enable();
        results();
    end
endmodule // cod_ctrl_tb_top

`default_nettype wire
